// file: rtl/eip_debounce.sv
/*
 * Debounce filter with a one-cycle pulse on the asserting edge.
 * Assumes the input is already synchronous to clk.
 */
module eip_debounce #(
	parameter int SETTLE_CYC = 25000
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic raw,
	output logic      rise
);

	localparam int CW = $clog2(SETTLE_CYC + 1);
	localparam logic [CW-1:0] CNT_END = CW'(SETTLE_CYC - 1);

	logic [CW-1:0] cnt_reg, cnt_next;
	logic          level_reg, level_next;
	logic          rise_reg, rise_next;

	// ************************************************
	// Filter
	// ************************************************
	// Level only flips once input held stable for the full settle time
	always_comb begin
		cnt_next   = cnt_reg;
		level_next = level_reg;
		rise_next  = 1'b0;
		if (raw == level_reg) begin
			cnt_next = '0;
		end else if (cnt_reg == CNT_END) begin
			cnt_next   = '0;
			level_next = raw;
			rise_next  = raw;                            // One capture per press
		end else begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_reg   <= '0;
			level_reg <= 1'b0;
			rise_reg  <= 1'b0;
		end else begin
			cnt_reg   <= cnt_next;
			level_reg <= level_next;
			rise_reg  <= rise_next;
		end
	end

	assign rise = rise_reg;

endmodule

// file: rtl/eip_index.sv
/*
 * Quadrature A/B and once-per-revolution index generator with a
 * settable index angle, Wishbone register access and restore of the
 * retained settings from non-volatile storage.
 * Assumes: a shaft step pulse from the angle sensor, synchronous pins,
 * a Wishbone slave reached by the serial configuration bridge.
 */
// Our own choices: the placing of the registers and register access over Wishbone.
// What this block does
// - One index pulse per revolution, always at the stored angle.
// - Rear button press stores the present shaft angle as index angle.
// - Index width selectable: 90 or 180 electrical degrees only.
// - Narrow index lasts 90 el, gated by both A and B.
// - Wide index lasts 180 el, gated by A only.
// - Setting input and a register write also set the index angle.
// - Configuration reaches the registers through the two-wire target link.
// - Default clockwise rotation makes A rise before B.
// - Count sense is direction parameter inverted when direction pin high.
module eip_index #(
	parameter int PPR          = eip_pkg::PPR_DEFAULT,
	parameter int SET_HOLD_CYC = eip_pkg::SET_HOLD_CYC,
	parameter int BTN_CYC      = eip_pkg::BTN_SETTLE_CYC
) (
	input  wire logic                      clk,
	input  wire logic                      reset,
	// Wishbone slave
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [3:0]                wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	// Shaft sensor
	input  wire logic                      shaft_step,
	input  wire logic                      shaft_ccw,
	// Pins
	input  wire logic                      set_button,
	input  wire logic                      set_input,
	input  wire logic                      dir_input,
	input  wire logic                      cfg_session,
	// Retained storage
	input  wire logic                      nv_valid,
	input  wire logic [eip_pkg::CYC_W-1:0] nv_index,
	input  wire logic                      nv_wide,
	output logic                           nv_store,
	output logic      [eip_pkg::CYC_W-1:0] nv_index_out,
	output logic                           nv_wide_out,
	// Encoder outputs
	output logic                           enc_a,
	output logic                           enc_b,
	output logic                           enc_z
);

	localparam int CW = eip_pkg::CYC_W;
	localparam logic [CW-1:0] CYC_LAST = CW'(PPR - 1);

	logic btn_rise, set_rise;

	// ************************************************
	// Debounce of the two capture sources
	// ************************************************
	eip_debounce #(.SETTLE_CYC(BTN_CYC)) u_btn (
		.clk   (clk),
		.reset (reset),
		.raw   (set_button & ~cfg_session),
		.rise  (btn_rise)
	);

	// Filter time equals least hold, so shorter pulses never capture
	eip_debounce #(.SETTLE_CYC(SET_HOLD_CYC)) u_set (
		.clk   (clk),
		.reset (reset),
		.raw   (set_input),
		.rise  (set_rise)
	);

	// ************************************************
	// State
	// ************************************************
	eip_pkg::eip_state_t state_reg, state_next;
	logic [CW-1:0] cyc_reg, cyc_next;
	logic [1:0]    ph_reg, ph_next;
	logic [CW-1:0] index_reg, index_next;
	logic          wide_reg, wide_next;
	logic          ccw_reg, ccw_next;
	logic          a_reg, a_next, b_reg, b_next, z_reg, z_next;
	logic          ack_reg, ack_next;
	logic [31:0]   dat_reg, dat_next;
	logic          store_reg, store_next;

	logic wb_req, wb_done, wr_ctrl, wr_index, grab, qa, qb, sense_flip;

	// Write decode, byte lane 0 (and lane 1 for the index)
	// Writes land at the edge where the master sees ack, so a dropped request changes nothing
	assign wb_req   = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wb_done  = wb_cyc_i & wb_stb_i & ack_reg;
	assign wr_ctrl  = wb_done & wb_we_i & wb_sel_i[0] & (wb_adr_i == eip_pkg::ADR_CTRL);
	assign wr_index = wb_done & wb_we_i & (wb_adr_i == eip_pkg::ADR_INDEX);
	assign grab     = btn_rise | set_rise | (wr_ctrl & wb_dat_i[eip_pkg::CTRL_GRAB]);

	// Raw quadrature: state 1 raises A, state 2 raises B on forward steps
	assign qa         = (ph_reg == 2'h1) | (ph_reg == eip_pkg::PH_BOTH_HI);
	assign qb         = (ph_reg == eip_pkg::PH_BOTH_HI) | (ph_reg == eip_pkg::PH_LAST);
	assign sense_flip = ccw_reg ^ dir_input;

	// ************************************************
	// Next-state logic
	// ************************************************
	always_comb begin
		state_next = state_reg;
		cyc_next   = cyc_reg;
		ph_next    = ph_reg;
		index_next = index_reg;
		wide_next  = wide_reg;
		ccw_next   = ccw_reg;
		store_next = 1'b0;
		a_next     = 1'b0;
		b_next     = 1'b0;
		z_next     = 1'b0;

		// Shaft angle tracking, wraps once per revolution
		if (shaft_step) begin
			if (!shaft_ccw) begin
				ph_next = ph_reg + 2'h1;
				if (ph_reg == eip_pkg::PH_LAST) begin
					cyc_next = (cyc_reg == CYC_LAST) ? '0 : cyc_reg + 1'b1;
				end
			end else begin
				ph_next = ph_reg - 2'h1;
				if (ph_reg == 2'h0) begin
					cyc_next = (cyc_reg == '0) ? CYC_LAST : cyc_reg - 1'b1;
				end
			end
		end

		case (state_reg)
			eip_pkg::EIP_RESTORE: begin
				// Outputs stay low until retained settings are in
				if (nv_valid) begin
					index_next = nv_index;
					wide_next  = nv_wide;
					state_next = eip_pkg::EIP_RUN;
				end
			end
			eip_pkg::EIP_RUN: begin
				if (wr_ctrl) begin
					wide_next  = wb_dat_i[eip_pkg::CTRL_WIDE];
					ccw_next   = wb_dat_i[eip_pkg::CTRL_CCW];
					store_next = 1'b1;
				end
				if (wr_index) begin
					if (wb_sel_i[0]) begin
						index_next[7:0] = wb_dat_i[7:0];
					end
					if (wb_sel_i[1]) begin
						index_next[CW-1:8] = wb_dat_i[CW-1:8];
					end
					store_next = 1'b1;
				end
				// Capture wins over a simultaneous index write
				if (grab) begin
					index_next = cyc_reg;
					store_next = 1'b1;
				end
				// Flipped sense swaps channels so the other one leads
				a_next = sense_flip ? qb : qa;
				b_next = sense_flip ? qa : qb;
				if (cyc_reg == index_reg) begin
					z_next = wide_reg ? a_next : (a_next & b_next);
				end
			end
			default: state_next = eip_pkg::EIP_RESTORE;
		endcase
	end

	// ************************************************
	// Register read and acknowledge
	// ************************************************
	// One wait state; unmapped addresses ack and read zero
	always_comb begin
		ack_next = wb_req;
		dat_next = dat_reg;
		if (wb_req && !wb_we_i) begin
			case (wb_adr_i)
				eip_pkg::ADR_CTRL: begin
					dat_next = '0;
					dat_next[eip_pkg::CTRL_WIDE] = wide_reg;
					dat_next[eip_pkg::CTRL_CCW]  = ccw_reg;
				end
				eip_pkg::ADR_INDEX: dat_next = {{(32-CW){1'b0}}, index_reg};
				eip_pkg::ADR_STATUS: begin
					dat_next = {{(32-CW){1'b0}}, cyc_reg};
					dat_next[eip_pkg::ST_READY] = (state_reg == eip_pkg::EIP_RUN);
					dat_next[eip_pkg::ST_A]     = a_reg;
					dat_next[eip_pkg::ST_B]     = b_reg;
					dat_next[eip_pkg::ST_Z]     = z_reg;
				end
				default: dat_next = '0;
			endcase
		end
	end

	// ************************************************
	// Registers
	// ************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= eip_pkg::EIP_RESTORE;
			cyc_reg   <= '0;
			ph_reg    <= '0;
			index_reg <= '0;
			wide_reg  <= eip_pkg::CTRL_WIDE_RST;
			ccw_reg   <= eip_pkg::CTRL_CCW_RST;
			a_reg     <= 1'b0;
			b_reg     <= 1'b0;
			z_reg     <= 1'b0;
			ack_reg   <= 1'b0;
			dat_reg   <= '0;
			store_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cyc_reg   <= cyc_next;
			ph_reg    <= ph_next;
			index_reg <= index_next;
			wide_reg  <= wide_next;
			ccw_reg   <= ccw_next;
			a_reg     <= a_next;
			b_reg     <= b_next;
			z_reg     <= z_next;
			ack_reg   <= ack_next;
			dat_reg   <= dat_next;
			store_reg <= store_next;
		end
	end

	assign wb_ack_o     = ack_reg;
	assign wb_dat_o     = dat_reg;
	assign enc_a        = a_reg;
	assign enc_b        = b_reg;
	assign enc_z        = z_reg;
	assign nv_store     = store_reg;
	assign nv_index_out = index_reg;                     // Valid with nv_store
	assign nv_wide_out  = wide_reg;

endmodule

// file: rtl/eip_pkg.sv
/*
 * Shared constants of the encoder index-pulse block: register map,
 * field positions, reset values and timing.
 * Assumes a 250 MHz system clock and 32-bit classic Wishbone.
 */
package eip_pkg;

	// ************************************************
	// Clock and timing
	// ************************************************
	localparam int CLK_PERIOD_PS  = 4000;
	localparam int SET_HOLD_US    = 100;                 // Least hold of the setting input
	localparam int SET_HOLD_CYC   = (SET_HOLD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int BTN_SETTLE_US  = 100;                 // Contact bounce settle time
	localparam int BTN_SETTLE_CYC = (BTN_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ************************************************
	// Shaft geometry
	// ************************************************
	localparam int PPR_DEFAULT = 1024;                   // Cycles per revolution
	localparam int CYC_W       = 16;
	localparam logic [1:0] PH_LAST   = 2'h3;             // Last quarter state of a cycle
	localparam logic [1:0] PH_BOTH_HI = 2'h2;            // Quarter where A and B are both high

	// ************************************************
	// Register map (byte addresses)
	// ************************************************
	localparam logic [3:0] ADR_CTRL   = 4'h0;
	localparam logic [3:0] ADR_INDEX  = 4'h4;
	localparam logic [3:0] ADR_STATUS = 4'h8;

	// CTRL fields
	localparam int CTRL_WIDE  = 0;                       // 1: 180 el gated by A
	localparam int CTRL_CCW   = 1;                       // Direction parameter
	localparam int CTRL_GRAB  = 2;                       // Write 1: capture current angle
	localparam logic CTRL_WIDE_RST = 1'b0;
	localparam logic CTRL_CCW_RST  = 1'b0;

	// STATUS fields above the cycle count
	localparam int ST_READY = 16;
	localparam int ST_A     = 17;
	localparam int ST_B     = 18;
	localparam int ST_Z     = 19;

	typedef enum logic {EIP_RESTORE, EIP_RUN} eip_state_t;

endpackage

// file: tb/eip_index_properties.sv
/* Port checker for eip_index: handshake, reset, index gating, capture.
   Assumes a bind onto eip_index with its hold parameters. */
module eip_index_chk #(
	parameter int SET_HOLD_CYC = 8,
	parameter int BTN_CYC      = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic set_button,
	input wire logic set_input,
	input wire logic cfg_session,
	input wire logic dir_input,
	input wire logic nv_valid,
	input wire logic nv_store,
	input wire logic nv_wide_out,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic enc_z
);
	// ************************************************
	// Helper state and properties
	// ************************************************
	logic seen_reg, seen_next;
	int   set_reg, set_next, btn_reg, btn_next;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// Consecutive high counts saturate so they never wrap
	always_comb begin
		seen_next = reset ? 1'b0 : (seen_reg | nv_valid);
		set_next  = (reset || !set_input) ? 0 : set_reg + int'(set_reg < SET_HOLD_CYC);
		btn_next  = (reset || !set_button || cfg_session) ? 0 : btn_reg + int'(btn_reg < BTN_CYC);
	end
	always_ff @(posedge clk) begin
		seen_reg <= seen_next;
		set_reg  <= set_next;
		btn_reg  <= btn_next;
	end

	AST_ACK_TAKE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	AST_RST_QUIET: assert property ($fell(reset) |-> !enc_a && !enc_b && !enc_z && !wb_ack_o) else $error("outputs live after reset");
	AST_NARROW: assert property (enc_z && !nv_wide_out && $stable(nv_wide_out) |-> enc_a && enc_b) else $error("narrow index not gated");
	AST_WIDE: assert property (enc_z && nv_wide_out && !dir_input |-> enc_a) else $error("wide index not gated by A");
	AST_RESTORE: assert property (!seen_reg |-> !enc_a && !enc_b && !enc_z) else $error("pulses before restore");
	AST_STORE_PULSE: assert property (nv_store |=> !nv_store) else $error("store pulse too long");
	AST_CAPTURE: assert property (nv_store && !$past(wb_ack_o) |->
		$past(set_reg) >= SET_HOLD_CYC || $past(btn_reg) >= BTN_CYC)
		else $error("capture without a long enough hold");
endmodule

bind eip_index eip_index_chk #(.SET_HOLD_CYC(SET_HOLD_CYC), .BTN_CYC(BTN_CYC)) chk_u (.clk(clk), .reset(reset),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .set_button(set_button), .set_input(set_input),
	.cfg_session(cfg_session), .dir_input(dir_input), .nv_valid(nv_valid), .nv_store(nv_store),
	.nv_wide_out(nv_wide_out), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z));

// file: tb/eip_qdec_model.sv
/* Counting electronics on the far side: quadrature decoder and index counter.
   Assumes A, B and Z are sampled on the encoder's own clock. */
module eip_qdec_model (
	input wire logic clk,
	input wire logic a,
	input wire logic b,
	input wire logic z
);
	int   pos     = 0;
	int   z_rises = 0;
	logic pa      = 1'b0;
	logic pb      = 1'b0;
	logic pz      = 1'b0;

	// Single-channel change counts; diagonal jumps are ignored like real counters
	always_ff @(posedge clk) begin
		pa <= a;
		pb <= b;
		pz <= z;
		if ((a ^ pa) != (b ^ pb)) begin
			pos <= (pa == b) ? pos + 1 : pos - 1;
		end
		if (z && !pz) begin
			z_rises <= z_rises + 1;
		end
	end
endmodule

// file: tb/tb_top.sv
/* Self-checking bench for eip_index with short hold counts.
   Assumes the bound checker and the counter model beside the block. */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic        shaft_step = 1'b0, shaft_ccw = 1'b0, set_button = 1'b0, set_input = 1'b0;
	logic        dir_input = 1'b0, cfg_session = 1'b0, nv_valid = 1'b0, nv_wide = 1'b1;
	logic        wb_ack_o, nv_store, nv_wide_out, enc_a, enc_b, enc_z;
	logic [3:0]  wb_adr_i = 4'h0;
	logic [15:0] nv_index = 16'h0002, nv_index_out;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, cnt;
	int          n_errors = 0, num_checks = 0, zc, r0, ns;

	always #2 clk = ~clk;

	eip_index #(.PPR(4), .SET_HOLD_CYC(8), .BTN_CYC(8)) dut_u (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .shaft_step(shaft_step), .shaft_ccw(shaft_ccw),
		.set_button(set_button), .set_input(set_input), .dir_input(dir_input), .cfg_session(cfg_session),
		.nv_valid(nv_valid), .nv_index(nv_index), .nv_wide(nv_wide), .nv_store(nv_store),
		.nv_index_out(nv_index_out), .nv_wide_out(nv_wide_out), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z));
	eip_qdec_model pm_u (.clk(clk), .a(enc_a), .b(enc_b), .z(enc_z));

	// ************************************************
	// Shared tasks
	// ************************************************
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Request held until ack is sampled, then one idle cycle
	task wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
		int w;
		w = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do begin
			@(posedge clk);
			w++;
		end while (wb_ack_o !== 1'b1 && w < 20);
		rd = wb_dat_o;
		n_errors += int'(w >= 20);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask
	// One quarter every four cycles; counts cycles with the index high
	// Drives on the rising edge, samples settled outputs on the falling edge
	task step(input int n, input logic ccw);
		zc = 0;
		for (int k = 0; k < n * 4; k++) begin
			shaft_step <= (k % 4 == 0);
			shaft_ccw <= ccw;
			@(negedge clk);
			zc += int'(enc_z);
			@(posedge clk);
		end
	endtask
	task hold(input bit pin, input int n);
		ns = 0;
		for (int k = 0; k < n + 20; k++) begin
			if (pin) set_input <= (k < n);
			else set_button <= (k < n);
			@(negedge clk);
			ns += int'(nv_store);
			@(posedge clk);
		end
	endtask

	// ************************************************
	// Scenarios
	// ************************************************
	task t_restore;
		step(3, 1'b0);
		check("restore index", zc, 0);
		check("restore moves", pm_u.pos, 0);
		nv_valid <= 1'b1;
		@(posedge clk);
		wb(1'b0, eip_pkg::ADR_INDEX, 32'h0);
		check("restored angle", rd, 32'h2);
		wb(1'b0, eip_pkg::ADR_CTRL, 32'h0);
		check("restored width", rd, 32'h1);
	endtask
	// Wide first: the gating check on A needs an unswapped sense
	task t_width;
		r0 = pm_u.z_rises;
		step(16, 1'b0);
		check("wide cycles", zc, 8);
		check("one per turn", pm_u.z_rises - r0, 1);
		wb(1'b1, eip_pkg::ADR_CTRL, 32'h0);
		check("stored width", nv_wide_out, 32'h0);
		wb(1'b0, eip_pkg::ADR_CTRL, 32'h0);
		check("width field", rd, 32'h0);
		step(16, 1'b0);
		check("narrow cycles", zc, 4);
	endtask
	task t_dir;
		r0 = pm_u.pos;
		step(4, 1'b0);
		check("cw counts up", pm_u.pos - r0, 4);
		dir_input <= 1'b1;
		repeat (2) @(posedge clk);
		r0 = pm_u.pos;
		step(4, 1'b0);
		check("pin flips", pm_u.pos - r0, -4);
		wb(1'b1, eip_pkg::ADR_CTRL, 32'h2);
		r0 = pm_u.pos;
		step(4, 1'b1);
		check("double flip ccw", pm_u.pos - r0, -4);
		wb(1'b1, eip_pkg::ADR_CTRL, 32'h0);
		dir_input <= 1'b0;
		wb(1'b0, eip_pkg::ADR_INDEX, 32'h0);
		check("index after reversal", rd, 32'h2);
	endtask
	task t_capture;
		step(5, 1'b0);
		wb(1'b0, eip_pkg::ADR_STATUS, 32'h0);
		cnt = {16'h0, rd[15:0]};
		hold(1'b0, 3);
		check("bounce ignored", ns, 0);
		cfg_session <= 1'b1;
		hold(1'b0, 20);
		cfg_session <= 1'b0;
		check("masked press", ns, 0);
		hold(1'b0, 20);
		check("one capture", ns, 1);
		check("stored angle", nv_index_out, cnt);
		wb(1'b0, eip_pkg::ADR_INDEX, 32'h0);
		check("button angle", rd, cnt);
		step(4, 1'b0);
		wb(1'b0, eip_pkg::ADR_STATUS, 32'h0);
		cnt = {16'h0, rd[15:0]};
		hold(1'b1, 12);
		check("input capture", ns, 1);
		wb(1'b0, eip_pkg::ADR_INDEX, 32'h0);
		check("input angle", rd, cnt);
		wb(1'b1, eip_pkg::ADR_INDEX, 32'h3);
		wb(1'b0, eip_pkg::ADR_INDEX, 32'h0);
		check("written angle", rd, 32'h3);
		wb(1'b1, eip_pkg::ADR_CTRL, 32'h4);
		wb(1'b0, eip_pkg::ADR_INDEX, 32'h0);
		check("register capture", rd, cnt);
		wb(1'b0, 4'hc, 32'h0);
		check("unmapped", rd, 32'h0);
	endtask

	// Watchdog far beyond the few hundred cycles the run needs
	initial begin
		#100000;
		n_errors++;
		report_and_stop;
	end
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_restore;
		t_width;
		t_dir;
		t_capture;
		report_and_stop;
	end
endmodule
